// ===== rtl/adc_ctl_pkg.sv
// Functional notes
// - voltage/temperature converter input is exactly one of three sources.
// - selecting the battery attenuator input enables its buffers automatically.
// - after a channel switch without chop, first valid result is third conversion.
// - ground pin floats when connect bit is 0; else direct or via resistor.
// - output rate set by filter code; 0xbf1d 4 Hz, 0x0007 1 kHz, 0x0000 8 kHz.
// - status bits 15 to 8 are flags only, never interrupt sources.
// - status bits 7 to 0 are ORed into one interrupt request.
// - each interrupt source has its own mask bit; masked sources stay silent.
// - reading the current result clears all result-ready bits.
// - with current converter off, voltage or temperature read clears ready bits.
// - unless the core sleeps, no new result is loaded while that channel's ready bit is set.
// - while the core sleeps, every new result overwrites the result register.
// - out-of-range result sets error flag and clamps to full scale.
// - error flag clears only when an in-range result is stored.
package adc_ctl_pkg;
  localparam int NCH = 3;
  localparam int CH_CUR = 0;
  localparam int CH_VOLT = 1;
  localparam int CH_TEMP = 2;
  localparam int STA_RDY_LSB = 0;
  localparam int STA_ERR_LSB = 12;
  localparam int STA_IRQ_W = 8;
  localparam int SETTLE_CONV = 3;
  localparam logic [15:0] POS_FULL = 16'h7fff;
  localparam logic [15:0] NEG_FULL = 16'h8000;
  localparam logic [15:0] STA_RESET = 16'h0000;
  localparam logic [15:0] FLT_4HZ = 16'hbf1d;
  localparam logic [15:0] FLT_1KHZ = 16'h0007;
  localparam logic [15:0] FLT_8KHZ = 16'h0000;
  localparam logic [15:0] FLT_RESET = FLT_1KHZ;

  typedef enum logic [1:0] {SRC_VBAT, SRC_EXT_TEMP, SRC_INT_TEMP} vt_src_t;
  typedef enum logic [1:0] {GS_FLOAT, GS_DIRECT, GS_RESISTOR} ground_switch_pin_t;

  // one conversion result from a modulator/filter
  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic [15:0] data;
  } conv_t;
endpackage

// ===== rtl/adc_result_status_control.sv
`timescale 1ns/10ps
module adc_result_status_control
  import adc_ctl_pkg::*;
#(
  parameter int SETTLE = SETTLE_CONV
)(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // configuration
  input wire vt_src_t vt_src,
  input wire logic chop_en,
  input wire logic cur_adc_en,
  input wire logic gnd_connect,
  input wire logic gnd_res_sel,
  input wire logic [15:0] filter_rate,
  input wire logic [7:0] irq_mask,
  input wire logic core_powered_down,
  // conversions from the analog front end
  input wire conv_t cur_conv,
  input wire conv_t vt_conv,
  // result register reads
  input wire logic rd_current,
  input wire logic rd_voltage,
  input wire logic rd_temperature,
  // outputs
  output vt_src_t vt_mux_sel,
  output logic atten_buf_en,
  output ground_switch_pin_t ground_switch_pin,
  output logic [15:0] filter_rate_out,
  output logic [15:0] current_result_reg,
  output logic [15:0] voltage_result_reg,
  output logic [15:0] temperature_result_reg,
  output logic [15:0] converter_status_reg,
  output logic adc_irq
);

  // =====================================================
  // source select and attenuator buffer
  logic [1:0] settle_cnt_r;
  vt_src_t src_prev_r;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      vt_mux_sel <= SRC_VBAT;
      atten_buf_en <= 1'b0;
    end
    else
    begin
      // an unused fourth code falls back to the battery input
      vt_mux_sel <= (vt_src == SRC_EXT_TEMP || vt_src == SRC_INT_TEMP) ? vt_src : SRC_VBAT;
      atten_buf_en <= !(vt_src == SRC_EXT_TEMP || vt_src == SRC_INT_TEMP);
    end
  end

  // =====================================================
  // settling after a channel switch
  logic vt_settled;
  logic vt_switch;
  assign vt_switch = (src_prev_r != vt_mux_sel) && !chop_en;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      src_prev_r <= SRC_VBAT;
      settle_cnt_r <= 2'h0;
    end
    else
    begin
      src_prev_r <= vt_mux_sel;
      if (vt_switch)
        settle_cnt_r <= 2'h0;
      else if (vt_conv.valid && settle_cnt_r < 2'(SETTLE - 1))
        settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end
  // the third conversion after a switch is the first one used
  assign vt_settled = (settle_cnt_r == 2'(SETTLE - 1));

  // =====================================================
  // ground switch and filter rate
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ground_switch_pin <= GS_FLOAT;
      filter_rate_out <= FLT_RESET;
    end
    else
    begin
      if (!gnd_connect)
        ground_switch_pin <= GS_FLOAT;
      else
        ground_switch_pin <= gnd_res_sel ? GS_RESISTOR : GS_DIRECT;
      filter_rate_out <= filter_rate;
    end
  end

  // =====================================================
  // result registers, ready and error flags
  logic [NCH-1:0] rdy_r;
  logic [NCH-1:0] err_r;
  logic [NCH-1:0] conv_in;
  logic [NCH-1:0] load;
  logic clr_all;
  logic [15:0] res_r [NCH];
  conv_t conv [NCH];

  assign conv[CH_CUR] = cur_conv;
  assign conv[CH_VOLT] = vt_conv;
  assign conv[CH_TEMP] = vt_conv;
  assign conv_in[CH_CUR] = cur_conv.valid;
  // a pulse on the switch edge is from the new input but still sees the old count
  assign conv_in[CH_VOLT] = vt_conv.valid && vt_settled && !vt_switch && vt_mux_sel == SRC_VBAT;
  assign conv_in[CH_TEMP] = vt_conv.valid && vt_settled && !vt_switch && vt_mux_sel != SRC_VBAT;
  assign clr_all = rd_current || (!cur_adc_en && (rd_voltage || rd_temperature));

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign load[g] = conv_in[g] && (!rdy_r[g] || core_powered_down);
      always_ff @(posedge clock)
      begin
        if (!nrst)
        begin
          res_r[g] <= 16'h0000;
          err_r[g] <= 1'b0;
          rdy_r[g] <= 1'b0;
        end
        else
        begin
          if (load[g])
          begin
            if (conv[g].over)
              res_r[g] <= POS_FULL;
            else if (conv[g].under)
              res_r[g] <= NEG_FULL;
            else
              res_r[g] <= conv[g].data;
            err_r[g] <= conv[g].over || conv[g].under;
          end
          // a new result wins over a same-cycle clearing read
          if (load[g])
            rdy_r[g] <= 1'b1;
          else if (clr_all)
            rdy_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // =====================================================
  // status and interrupt
  logic [15:0] sta_nxt;
  always_comb
  begin
    sta_nxt = STA_RESET;
    sta_nxt[STA_RDY_LSB +: NCH] = rdy_r;
    sta_nxt[STA_ERR_LSB +: NCH] = err_r;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      converter_status_reg <= STA_RESET;
      current_result_reg <= 16'h0000;
      voltage_result_reg <= 16'h0000;
      temperature_result_reg <= 16'h0000;
      adc_irq <= 1'b0;
    end
    else
    begin
      converter_status_reg <= sta_nxt;
      current_result_reg <= res_r[CH_CUR];
      voltage_result_reg <= res_r[CH_VOLT];
      temperature_result_reg <= res_r[CH_TEMP];
      // upper byte is never part of the request
      adc_irq <= |(sta_nxt[STA_IRQ_W-1:0] & ~irq_mask);
    end
  end

  // =====================================================
  // checks
  property p_gnd_float;
    @(posedge clock) disable iff (!nrst)
    !gnd_connect |=> ground_switch_pin == GS_FLOAT;
  endproperty
  a_gnd_float: assert property (p_gnd_float) else $error("ground pin not floating");

  property p_atten;
    @(posedge clock) disable iff (!nrst)
    vt_src == SRC_VBAT |=> atten_buf_en && vt_mux_sel == SRC_VBAT;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuator buffer not enabled");

  property p_irq_masked;
    @(posedge clock) disable iff (!nrst)
    (&irq_mask) |=> !adc_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq asserted");

  property p_irq_rdy;
    @(posedge clock) disable iff (!nrst)
    (rdy_r[CH_CUR] && !irq_mask[STA_RDY_LSB]) |=> adc_irq;
  endproperty
  a_irq_rdy: assert property (p_irq_rdy) else $error("ready did not raise irq");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
    (rdy_r[CH_CUR] && !core_powered_down) |=> res_r[CH_CUR] == $past(res_r[CH_CUR]);
  endproperty
  a_hold: assert property (p_hold) else $error("result overwritten while ready");

  property p_clear;
    @(posedge clock) disable iff (!nrst)
    (rd_current && !load[CH_VOLT]) |=> !rdy_r[CH_VOLT];
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear ready");

  property p_clamp;
    @(posedge clock) disable iff (!nrst)
    (load[CH_CUR] && cur_conv.over) |=> res_r[CH_CUR] == POS_FULL && err_r[CH_CUR];
  endproperty
  a_clamp: assert property (p_clamp) else $error("overrange not clamped");

  property p_ready_set;
    @(posedge clock) disable iff (!nrst)
    load[CH_TEMP] |=> rdy_r[CH_TEMP] ##1 converter_status_reg[STA_RDY_LSB + CH_TEMP];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set on load");

  property p_settle;
    @(posedge clock) disable iff (!nrst)
    (src_prev_r != vt_mux_sel && !chop_en) |-> (!conv_in[CH_VOLT] && !conv_in[CH_TEMP])
      ##1 (!conv_in[CH_VOLT] && !conv_in[CH_TEMP]);
  endproperty
  a_settle: assert property (p_settle) else $error("unsettled result used");
endmodule

// ===== testbench/conv_source.sv
`timescale 1ns/10ps
// =====================================
// front end model: one-cycle conversion pulses
module conv_source
  import adc_ctl_pkg::*;
(
  // clock
  input wire logic clock,
  // conversions
  output conv_t cur_conv,
  output conv_t vt_conv
);
  initial
  begin
    cur_conv = '0;
    vt_conv = '0;
  end
  task automatic send(input logic to_vt, input logic [15:0] d, input logic ov, input logic un);
    conv_t c;
    c = '{valid: 1'b1, over: ov, under: un, data: d};
    if (to_vt) vt_conv = c;
    else cur_conv = c;
    @(posedge clock);
    #1;
    // idle shows inverted fields so stale data never looks valid
    c = '{valid: 1'b0, over: ~ov, under: ~un, data: ~d};
    if (to_vt) vt_conv = c;
    else cur_conv = c;
  endtask
endmodule

// ===== testbench/adc_result_status_control_bench.sv
`timescale 1ns/10ps
module adc_result_status_control_bench;
  import adc_ctl_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  vt_src_t vt_src = SRC_VBAT;
  logic chop_en = 1'b0;
  logic cur_en = 1'b1;
  logic gnd_c = 1'b0;
  logic gnd_r = 1'b0;
  logic pd = 1'b0;
  logic [15:0] flt = 16'h0000;
  logic [7:0] mask = 8'h00;
  logic rd_c = 1'b0;
  logic rd_v = 1'b0;
  logic rd_t = 1'b0;
  conv_t cur_conv;
  conv_t vt_conv;
  vt_src_t mux;
  ground_switch_pin_t gsw;
  logic atten;
  logic irq;
  logic [15:0] frate, cur_r, volt_r, temp_r, sta;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  conv_source i_src (.clock(clock), .cur_conv(cur_conv), .vt_conv(vt_conv));
  adc_result_status_control i_dut (.clock(clock), .nrst(nrst), .vt_src(vt_src),
    .chop_en(chop_en), .cur_adc_en(cur_en), .gnd_connect(gnd_c), .gnd_res_sel(gnd_r),
    .filter_rate(flt), .irq_mask(mask), .core_powered_down(pd), .cur_conv(cur_conv),
    .vt_conv(vt_conv), .rd_current(rd_c), .rd_voltage(rd_v), .rd_temperature(rd_t),
    .vt_mux_sel(mux), .atten_buf_en(atten), .ground_switch_pin(gsw),
    .filter_rate_out(frate), .current_result_reg(cur_r), .voltage_result_reg(volt_r),
    .temperature_result_reg(temp_r), .converter_status_reg(sta), .adc_irq(irq));
  // =====================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rdp(input logic [2:0] m);
    {rd_t, rd_v, rd_c} = m;
    tick(1);
    {rd_t, rd_v, rd_c} = 3'b000;
    tick(2);
  endtask
  task automatic conv(input logic to_vt, input logic [15:0] d, input logic ov, input logic un);
    i_src.send(to_vt, d, ov, un);
    tick(2);
  endtask
  task automatic results();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // =====================================
  // scenarios
  task automatic t_config();
    logic [15:0] codes [4];
    codes = '{FLT_4HZ, FLT_1KHZ, FLT_8KHZ, FLT_RESET};
    // code 3 is unused and must fall back to the battery input
    for (int i = 0; i < 4; i++)
    begin
      vt_src = vt_src_t'(i);
      flt = codes[i];
      tick(2);
      chk("mux", 16'(i % 3), 16'(mux));
      chk("atten", {15'h0, i == 0 || i == 3}, {15'h0, atten});
      chk("rate", codes[i], frate);
    end
    for (int i = 0; i < 4; i++)
    begin
      {gnd_c, gnd_r} = 2'(i);
      tick(2);
      chk("gnd", (i < 2) ? 16'h0000 : 16'(i - 1), 16'(gsw));
    end
  endtask
  task automatic t_settle();
    vt_src = SRC_VBAT;
    tick(3);
    conv(1'b1, 16'h0101, 1'b0, 1'b0);
    conv(1'b1, 16'h0202, 1'b0, 1'b0);
    chk("sta early", 16'h0000, sta);
    conv(1'b1, 16'h0303, 1'b0, 1'b0);
    chk("volt", 16'h0303, volt_r);
    chk("sta", 16'h0002, sta);
    rdp(3'b010);
    chk("sta rd v en", 16'h0002, sta);
    cur_en = 1'b0;
    rdp(3'b010);
    chk("sta rd v", 16'h0000, sta);
    cur_en = 1'b1;
    chop_en = 1'b1;
    vt_src = SRC_EXT_TEMP;
    tick(3);
    conv(1'b1, 16'h0404, 1'b0, 1'b0);
    chk("temp", 16'h0404, temp_r);
    rdp(3'b100);
    chk("sta rd t en", 16'h0004, sta);
  endtask
  task automatic t_current();
    mask = 8'h01;
    conv(1'b0, 16'h1234, 1'b0, 1'b0);
    chk("sta", 16'h0005, sta);
    mask = 8'h05;
    tick(2);
    chk("irq masked", 16'h0000, {15'h0, irq});
    mask = 8'h00;
    tick(2);
    chk("irq", 16'h0001, {15'h0, irq});
    chk("sta src", 16'h0005, sta);
    conv(1'b0, 16'h5678, 1'b0, 1'b0);
    chk("cur held", 16'h1234, cur_r);
    rdp(3'b010);
    rdp(3'b001);
    chk("sta rd c", 16'h0000, sta);
    chk("irq off", 16'h0000, {15'h0, irq});
  endtask
  task automatic t_range();
    conv(1'b0, 16'h0011, 1'b1, 1'b0);
    chk("clamp pos", POS_FULL, cur_r);
    rdp(3'b001);
    chk("sta err", 16'h1000, sta);
    chk("irq err", 16'h0000, {15'h0, irq});
    conv(1'b0, 16'h0012, 1'b0, 1'b1);
    chk("clamp neg", NEG_FULL, cur_r);
    rdp(3'b001);
    conv(1'b0, 16'h0022, 1'b0, 1'b0);
    chk("sta ok", 16'h0001, sta);
    pd = 1'b1;
    conv(1'b0, 16'h0bbb, 1'b0, 1'b0);
    chk("cur sleep", 16'h0bbb, cur_r);
    pd = 1'b0;
    cur_en = 1'b0;
    rdp(3'b100);
    chk("sta rd t", 16'h0000, sta);
    cur_en = 1'b1;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    results();
  end
  initial
  begin
    tick(2);
    nrst = 1'b1;
    tick(1);
    t_config();
    t_settle();
    t_current();
    t_range();
    results();
  end
endmodule
